// >>> hdl/pla_station.sv
// Party line address station with AXI4-Lite register access
//
// Chosen here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "pla_station_regs.svh"

// Functional notes
// - Zero sent 2:1 high, one 1:2
// - Send eight bits, then inhibit driver
// - Classify pulse widths, shift into register
// - Own address match enables reply transmission
// - One wrong bit stops the exchange
// - Master clock divider cleared while inhibited
// - Phase counter cycles 00, 01, 11
// - Code bit selects mark output, rate/6
// - Pulse end advances bit counter, shifts
// - Eighth pulse sets transmit done, stops all
// - Leading edge fires midway width one-shot
// - Received trailing edge shifts one-shot level
// - Narrow pulse gives one, wide gives zero
// - Match clears done, requests parallel load
// - Load reply code, return to shift mode
// - Transmitting isolates register from receiver
// - Follow-on data passed only after match
module pla_station (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  // AXI4-Lite write
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Party line
  input  wire logic        line_rx,
  output logic             line_tx,
  output logic             line_tx_oe
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [3:0]             presc;
  logic [2:0]             bit_counter, rx_count, own_tail;
  logic [7:0]             code_shift_reg, own_addr, reply_code, oneshot_len, width_one_shot, rx_data;
  logic [31:0]            rd_word;
  pla_pkg::pla_phase_type phase;
  logic                   clock_divide_flop, transmit_done_flop, load_pending, reply_en, addr_ok, rx_valid;
  logic                   rx_s1, rx_s2, rx_s3, next_line_tx, master_tick, div_tick, running;
  logic                   short_mark_output, long_mark_output, current_code_bit, pulse_end;
  logic                   receive_gate_enable, receive_clock_gate, receive_data_gate, serial_code_in;
  logic                   address_match_gate, os_on, rx_rise, rx_fall;
  logic                   wr_go, rd_go, start_req, clr_ok_req, rd_hit, wr_hit;

  // ----------------------------------------
  // Derived strobes
  // ----------------------------------------
  // Master tick and divided clock falling edge
  assign master_tick = (presc == 4'(`PLA_MASTER_DIV - 1));
  assign div_tick    = master_tick && clock_divide_flop;
  assign running     = !transmit_done_flop && !load_pending;
  // Mark outputs of the phase counter
  assign short_mark_output = (phase != pla_pkg::PH_REST);
  assign long_mark_output  = (phase == pla_pkg::PH_LONG);
  assign current_code_bit  = code_shift_reg[0];
  assign pulse_end = div_tick && running && (phase == pla_pkg::PH_LONG);
  // Receive path gating, shut until our own last trailing edge has left the synchroniser
  assign receive_gate_enable = transmit_done_flop && !load_pending && !line_tx_oe && (own_tail == 3'h0);
  assign receive_clock_gate  = rx_fall && receive_gate_enable;
  assign os_on               = (width_one_shot != 8'h00);
  assign receive_data_gate   = os_on && receive_gate_enable;
  assign serial_code_in      = receive_data_gate;
  assign rx_rise             = rx_s2 && !rx_s3;
  assign rx_fall             = !rx_s2 && rx_s3;
  // Continuous comparison against own address
  assign address_match_gate = receive_gate_enable && (code_shift_reg == own_addr);
  // Line level: zero uses the long-high mark, one the short-high mark
  assign next_line_tx = running && (current_code_bit ? long_mark_output : short_mark_output);

  // ----------------------------------------
  // Master clock prescaler and divide-by-two
  // ----------------------------------------
  // Held clear while inhibited so restart is in phase
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      presc             <= 4'h0;
      clock_divide_flop <= 1'b0;
    end else if (transmit_done_flop) begin
      presc             <= 4'h0;
      clock_divide_flop <= 1'b0;
    end else if (master_tick) begin
      presc             <= 4'h0;
      clock_divide_flop <= !clock_divide_flop;
    end else begin
      presc <= presc + 4'h1;
    end
  end

  // Three state pulse phase counter
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      phase <= pla_pkg::PH_REST;
    end else if (!running) begin
      phase <= pla_pkg::PH_REST;
    end else if (div_tick) begin
      unique case (phase)
        pla_pkg::PH_REST:  phase <= pla_pkg::PH_SHORT;
        pla_pkg::PH_SHORT: phase <= pla_pkg::PH_LONG;
        pla_pkg::PH_LONG:  phase <= pla_pkg::PH_REST;
        default:           phase <= pla_pkg::PH_REST;
      endcase
    end
  end

  // Bit counter, advanced at each pulse end
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      bit_counter <= 3'h0;
    end else if (transmit_done_flop) begin
      bit_counter <= 3'h0;
    end else if (pulse_end) begin
      bit_counter <= bit_counter + 3'h1;
    end
  end

  // Transmit done flop and pending parallel load
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      transmit_done_flop <= 1'b1;
      load_pending       <= 1'b0;
    end else begin
      if (pulse_end && bit_counter == 3'(`PLA_CODE_BITS - 1)) begin
        transmit_done_flop <= 1'b1;
      end else if ((address_match_gate && reply_en) || (start_req && transmit_done_flop)) begin
        transmit_done_flop <= 1'b0;
        load_pending       <= 1'b1;
      end
      if (div_tick && load_pending) begin
        load_pending <= 1'b0;
      end
    end
  end

  // Code shift register: load, transmit shift, receive shift
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      code_shift_reg <= 8'h00;
    end else if (div_tick && load_pending) begin
      code_shift_reg <= reply_code;
    end else if (pulse_end) begin
      code_shift_reg <= {1'b0, code_shift_reg[7:1]};
    end else if (receive_clock_gate) begin
      code_shift_reg <= {serial_code_in, code_shift_reg[7:1]};
    end
  end

  // Driver output and enable
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      line_tx    <= 1'b0;
      line_tx_oe <= 1'b0;
    end else begin
      line_tx    <= next_line_tx;
      line_tx_oe <= !transmit_done_flop;
    end
  end

  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  // Line input synchroniser, edge history and own driver history
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_s1    <= 1'b0;
      rx_s2    <= 1'b0;
      rx_s3    <= 1'b0;
      own_tail <= 3'h0;
    end else begin
      rx_s1    <= line_rx;
      rx_s2    <= rx_s1;
      rx_s3    <= rx_s2;
      own_tail <= {own_tail[1:0], line_tx_oe};
    end
  end

  // Width one-shot, fired by leading edge
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      width_one_shot <= 8'h00;
    end else if (rx_rise) begin
      width_one_shot <= oneshot_len;
    end else if (os_on) begin
      width_one_shot <= width_one_shot - 8'h01;
    end
  end

  // Follow-on data capture, gated by address match
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_count <= 3'h0;
      rx_data  <= 8'h00;
      rx_valid <= 1'b0;
      addr_ok  <= 1'b0;
    end else begin
      if (receive_clock_gate) begin
        rx_count <= rx_count + 3'h1;
      end
      if (receive_clock_gate && rx_count == 3'(`PLA_CODE_BITS - 1) && addr_ok) begin
        rx_data  <= {serial_code_in, code_shift_reg[7:1]};
        rx_valid <= 1'b1;
      end else if (rd_go && araddr == `PLA_RX_DATA_OFS) begin
        rx_valid <= 1'b0;
      end
      if (address_match_gate) begin
        addr_ok <= 1'b1;
      end else if (clr_ok_req) begin
        addr_ok <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  // Address and data taken together, one write at a time
  assign awready    = awvalid && wvalid && !bvalid;
  assign wready     = awready;
  assign wr_go      = awready;
  assign arready    = !rvalid;
  assign rd_go      = arvalid && arready;
  assign start_req  = wr_go && wstrb[0] && wdata[`PLA_CTRL_START] && awaddr == `PLA_CTRL_OFS;
  assign clr_ok_req = wr_go && wstrb[0] && wdata[`PLA_CTRL_CLR_OK] && awaddr == `PLA_CTRL_OFS;
  assign wr_hit     = (awaddr == `PLA_CTRL_OFS) || (awaddr == `PLA_OWN_ADDR_OFS) ||
                      (awaddr == `PLA_REPLY_OFS) || (awaddr == `PLA_ONESHOT_OFS);

  // Writable registers
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      own_addr    <= `PLA_OWN_ADDR_RST;
      reply_code  <= `PLA_REPLY_RST;
      oneshot_len <= 8'(`PLA_ONE_SHOT_CYC);
      reply_en    <= `PLA_REPLY_EN_RST;
    end else if (wr_go && wstrb[0]) begin
      unique case (awaddr)
        `PLA_CTRL_OFS:     reply_en    <= wdata[`PLA_CTRL_REPLY];
        `PLA_OWN_ADDR_OFS: own_addr    <= wdata[7:0];
        `PLA_REPLY_OFS:    reply_code  <= wdata[7:0];
        `PLA_ONESHOT_OFS:  oneshot_len <= wdata[7:0];
        default:           reply_en    <= reply_en;
      endcase
    end
  end

  // Write response
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      bvalid <= 1'b0;
      bresp  <= pla_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid <= 1'b1;
      bresp  <= wr_hit ? pla_pkg::RESP_OKAY : pla_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Read mux
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    unique case (araddr)
      `PLA_CTRL_OFS:     rd_word[`PLA_CTRL_REPLY] = reply_en;
      `PLA_OWN_ADDR_OFS: rd_word[7:0] = own_addr;
      `PLA_REPLY_OFS:    rd_word[7:0] = reply_code;
      `PLA_ONESHOT_OFS:  rd_word[7:0] = oneshot_len;
      `PLA_STATUS_OFS:   rd_word = {16'h0000, code_shift_reg, 1'b0, bit_counter,
                                    rx_valid, addr_ok, address_match_gate, transmit_done_flop};
      `PLA_RX_DATA_OFS:  rd_word[7:0] = rx_data;
      default:           rd_hit = 1'b0;
    endcase
  end

  // Read response
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= pla_pkg::RESP_OKAY;
    end else if (rd_go) begin
      rvalid <= 1'b1;
      rdata  <= rd_word;
      rresp  <= rd_hit ? pla_pkg::RESP_OKAY : pla_pkg::RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  a_zero_long_high: assert property (running && phase == pla_pkg::PH_SHORT && !current_code_bit |=> line_tx)
    else $error("zero bit not high in short phase");
  a_one_short_high: assert property (running && phase == pla_pkg::PH_SHORT && current_code_bit |=> !line_tx)
    else $error("one bit high in short phase");
  a_eighth_stops: assert property (pulse_end && bit_counter == 3'h7 |=> transmit_done_flop ##1 !line_tx_oe)
    else $error("eighth pulse did not inhibit driver");
  a_div_cleared: assert property (transmit_done_flop && $past(transmit_done_flop) |-> presc == 4'h0 && !clock_divide_flop)
    else $error("divider runs while inhibited");
  a_phase_order: assert property (running && div_tick && phase == pla_pkg::PH_SHORT |=> phase == pla_pkg::PH_LONG)
    else $error("phase counter out of order");
  a_rx_shift_in: assert property (receive_clock_gate && !load_pending |=> code_shift_reg[7] == $past(os_on))
    else $error("received level not shifted in");
  a_match_loads: assert property (address_match_gate && reply_en |=> load_pending && !transmit_done_flop)
    else $error("match did not request reply");
  a_reply_loaded: assert property (div_tick && load_pending |=> code_shift_reg == $past(reply_code) && !load_pending)
    else $error("reply code not loaded");
  a_oneshot_fire: assert property (rx_rise |=> width_one_shot == $past(oneshot_len))
    else $error("one-shot not fired");

  c_reply_sent: cover property (pulse_end && bit_counter == 3'h7);
  c_match_seen: cover property (address_match_gate && reply_en);
  c_data_taken: cover property (receive_clock_gate && rx_count == 3'h7 && addr_ok);

endmodule // pla_station

// >>> hdl/pla_station_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef PLA_STATION_REGS_SVH
`define PLA_STATION_REGS_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define PLA_CTRL_OFS     8'h00
`define PLA_OWN_ADDR_OFS 8'h04
`define PLA_REPLY_OFS    8'h08
`define PLA_ONESHOT_OFS  8'h0c
`define PLA_STATUS_OFS   8'h10
`define PLA_RX_DATA_OFS  8'h14
// ----------------------------------------
// Field positions
// ----------------------------------------
`define PLA_CTRL_START   0
`define PLA_CTRL_REPLY   1
`define PLA_CTRL_CLR_OK  2
`define PLA_ST_DONE      0
`define PLA_ST_MATCH     1
`define PLA_ST_ADDR_OK   2
`define PLA_ST_RX_VALID  3
// ----------------------------------------
// Reset values
// ----------------------------------------
`define PLA_OWN_ADDR_RST 8'h65
`define PLA_REPLY_RST    8'hb4
`define PLA_REPLY_EN_RST 1'h1
// ----------------------------------------
// Timing
// ----------------------------------------
`define PLA_SYS_CLK_KHZ  40000
`define PLA_SYS_CLK_NS   25
`define PLA_MASTER_KHZ   4000
`define PLA_MASTER_DIV   (`PLA_SYS_CLK_KHZ / `PLA_MASTER_KHZ)
`define PLA_ONE_SHOT_NS  1250
`define PLA_ONE_SHOT_CYC ((`PLA_ONE_SHOT_NS + `PLA_SYS_CLK_NS - 1) / `PLA_SYS_CLK_NS)
`define PLA_CODE_BITS    8
`endif

// >>> hdl/pla_pkg.sv
// Types shared by the party line station
package pla_pkg;
  // Pulse phase counter, Gray along 00 -> 01 -> 11
  typedef enum logic [1:0] {
    PH_REST  = 2'b00,
    PH_SHORT = 2'b01,
    PH_LONG  = 2'b11
  } pla_phase_type;
  typedef enum logic [1:0] {
    RESP_OKAY   = 2'b00,
    RESP_SLVERR = 2'b10
  } pla_resp_type;
endpackage

// >>> verif/pla_far_station.sv
// Behavioural remote station facing the station under test
`timescale 1ns/100ps
module pla_far_station #(
  parameter logic [7:0] OWN_CODE   = 8'hb4,
  parameter logic [7:0] REPLY_CODE = 8'h65,
  parameter int         CORRUPT_AT = 2,
  parameter int         REPLY_GAP  = 30
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  // Near station driver
  input  wire logic       near_tx,
  input  wire logic       near_oe,
  // Own driver
  output logic            far_tx,
  output logic            far_oe,
  // Observations of near frames
  output logic [7:0]      rx_code,
  output logic [7:0]      frame_cnt,
  output logic [7:0]      bad_cnt,
  output logic [3:0]      frame_bits
);
  int         width;
  int         replies;
  logic [7:0] shift;
  logic [7:0] code;
  logic [3:0] bits;
  logic       prev_tx;
  logic       prev_oe;
  event       reply_ev;

  // Width decode of each near pulse, frame end on driver release
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      {width, shift, bits, prev_tx, prev_oe} = '0;
      {rx_code, frame_cnt, bad_cnt, frame_bits} <= '0;
    end else begin
      if (near_oe && near_tx) width = width + 1;
      if (prev_oe && prev_tx && !near_tx) begin
        if (width != 20 && width != 40) bad_cnt <= bad_cnt + 8'h01;
        shift = {width < 30, shift[7:1]};
        bits  = bits + 4'h1;
        width = 0;
      end
      if (prev_oe && !near_oe) begin
        rx_code    <= shift;
        frame_bits <= bits;
        frame_cnt  <= frame_cnt + 8'h01;
        if (shift == OWN_CODE) ->reply_ev;
        bits = 4'h0;
      end
      prev_tx = near_tx;
      prev_oe = near_oe;
    end
  end

  // Hold the driven level for a number of cycles
  task automatic hold(input logic v, input int n);
    far_tx <= v;
    repeat (n) @(posedge sys_clk);
  endtask

  // Reply with REPLY_CODE, one bit flipped on the chosen reply
  initial begin
    far_tx  = 1'b0;
    far_oe  = 1'b0;
    replies = 0;
    forever begin
      @(reply_ev);
      replies++;
      code = REPLY_CODE ^ ((replies == CORRUPT_AT) ? 8'h01 : 8'h00);
      repeat (REPLY_GAP) @(posedge sys_clk);
      while (near_oe) @(posedge sys_clk);
      far_oe <= 1'b1;
      for (int i = 0; i < 8; i++) begin
        hold(1'b0, 20);
        hold(1'b1, code[i] ? 20 : 40);
        if (code[i]) hold(1'b0, 20);
      end
      far_tx <= 1'b0;
      far_oe <= 1'b0;
    end
  end
endmodule // pla_far_station

// >>> verif/pla_station_tb.sv
// Self-checking bench for the party line station
`timescale 1ns/100ps
`include "pla_station_regs.svh"
module pla_station_tb;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        sys_clk, arst_n;
  logic [7:0]  awaddr, araddr;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp, rsp;
  logic        line_rx, line_tx, line_tx_oe, far_tx, far_oe;
  logic [7:0]  rx_code, frame_cnt, bad_cnt;
  logic [3:0]  frame_bits;
  int          error_cnt, tests_run;
  logic [7:0]  rst_addr [5] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h18};
  logic [31:0] rst_val  [5] = '{32'h65, 32'hb4, 32'h32, 32'h01, 32'h00};
  logic [1:0]  rst_rsp  [5] = '{2'b00, 2'b00, 2'b00, 2'b00, 2'b10};

  // ----------------------------------------
  // Design, partner and shared line
  // ----------------------------------------
  // Idle line reads as no pulse
  assign line_rx = far_oe ? far_tx : (line_tx_oe ? line_tx : 1'b0);

  pla_station u_pla_station (.sys_clk(sys_clk), .arst_n(arst_n), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .line_rx(line_rx), .line_tx(line_tx),
    .line_tx_oe(line_tx_oe));

  pla_far_station u_pla_far_station (.sys_clk(sys_clk), .arst_n(arst_n), .near_tx(line_tx),
    .near_oe(line_tx_oe), .far_tx(far_tx), .far_oe(far_oe), .rx_code(rx_code), .frame_cnt(frame_cnt),
    .bad_cnt(bad_cnt), .frame_bits(frame_bits));

  // Clock
  initial sys_clk = 1'b0;
  always #12.5 sys_clk = ~sys_clk;

  // ----------------------------------------
  // Bus tasks and comparisons
  // ----------------------------------------
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do @(posedge sys_clk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    bready  <= 1'b1;
    do @(posedge sys_clk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    do @(posedge sys_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready  <= 1'b1;
    do @(posedge sys_clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask

  // Wait for the partner to see a number of frames
  task automatic wait_frames(input logic [7:0] n);
    for (int i = 0; i < 3000 && frame_cnt !== n; i++) @(posedge sys_clk);
    chk_word("frame count", {24'h0, n}, {24'h0, frame_cnt});
  endtask

  task automatic finish_test;
    $display("Counts: %0d comparisons, %0d mismatches", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Watchdog for a hung handshake; a lost frame is caught by the wait_frames time limit
  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    finish_test();
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    {arst_n, awaddr, araddr, awvalid, wvalid, bready, arvalid, rready, wdata} = '0;
    {error_cnt, tests_run} = '0;
    repeat (6) @(posedge sys_clk);
    arst_n <= 1'b1;
    // Reset values and an unmapped read
    for (int i = 0; i < 5; i++) begin
      axi_rd(rst_addr[i], rd, rsp);
      chk_word("reset value", rst_val[i], rd);
      chk_resp("read response", rst_rsp[i], rsp);
    end
    $display("test reset values done");
    // Address register round trip, unmapped write, one-shot midway
    axi_wr(`PLA_OWN_ADDR_OFS, 32'h5a, rsp);
    axi_rd(`PLA_OWN_ADDR_OFS, rd, rsp);
    chk_word("own address", 32'h5a, rd);
    axi_wr(8'h1c, 32'h11, rsp);
    chk_resp("unmapped write", 2'b10, rsp);
    axi_wr(`PLA_OWN_ADDR_OFS, 32'h65, rsp);
    axi_wr(`PLA_ONESHOT_OFS, 32'h1e, rsp);
    chk_resp("one-shot write", 2'b00, rsp);
    $display("test registers done");
    // Start, reply on match, stop after a corrupted code
    axi_wr(`PLA_CTRL_OFS, 32'h03, rsp);
    wait_frames(8'h01);
    chk_word("first code", 32'hb4, {24'h0, rx_code});
    chk_word("first bit count", 32'h8, {28'h0, frame_bits});
    wait_frames(8'h02);
    chk_word("reply code", 32'hb4, {24'h0, rx_code});
    chk_word("reply bit count", 32'h8, {28'h0, frame_bits});
    chk_word("pulse widths", 32'h0, {24'h0, bad_cnt});
    repeat (1500) @(posedge sys_clk);
    chk_word("frames after fault", 32'h2, {24'h0, frame_cnt});
    axi_rd(`PLA_STATUS_OFS, rd, rsp);
    chk_word("status after fault", 32'h640d, rd & 32'hff0f);
    axi_rd(`PLA_RX_DATA_OFS, rd, rsp);
    chk_word("follow-on data", 32'h64, rd);
    axi_rd(`PLA_STATUS_OFS, rd, rsp);
    chk_word("data valid cleared", 32'h0, rd & 32'h8);
    $display("test ping-pong done");
    // Reply disable and clear of the match memory
    axi_wr(`PLA_CTRL_OFS, 32'h04, rsp);
    axi_rd(`PLA_CTRL_OFS, rd, rsp);
    chk_word("reply enable", 32'h0, rd);
    axi_rd(`PLA_STATUS_OFS, rd, rsp);
    chk_word("address ok cleared", 32'h0, rd & 32'h4);
    $display("test control done");
    finish_test();
  end
endmodule // pla_station_tb
